// file: plc_pkg.sv
// Shared constants, types and register map of the port loopback block
// Assumes a two-port card: index 0 is the client port, 1 the trunk port
package plc_pkg;

	// ==========================================================
	// Sizes
	localparam int DATA_W = 16; // Line word width
	localparam int REG_W = 16; // Register data width
	localparam int ADDR_W = 4; // Register byte address width
	localparam int CARD_W = 3; // Card kind strap width
	localparam int LOOP_W = 2; // Loop selector width
	localparam int SVC_W = 2; // Service state width
	localparam int N_PORTS = 2; // Client and trunk
	localparam int PORT_CLIENT = 0;
	localparam int PORT_TRUNK = 1;
	localparam int FIFO_DEPTH_DEF = 4; // Trunk transmit buffer depth
	localparam int SYNC_STAGES = 3; // Strap synchroniser length

	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CFG = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CLIENT = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_TRUNK = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

	// ==========================================================
	// Field positions
	localparam int CFG_SDH_BIT = 0; // Port flavour, 1 = SDH style
	localparam int CFG_CARD_LSB = 4; // Card kind, read only
	localparam int CTL_MAINT_BIT = 0; // Maintenance admin request
	localparam int CTL_LOOP_LSB = 1; // Loop selector
	localparam int ST_SVC_LSB = 0; // Two service states, 2 bits each
	localparam int ST_FAC_LSB = 4; // Facility loop condition per port
	localparam int ST_TERM_LSB = 6; // Terminal loop condition per port
	localparam int ST_SUPP_LSB = 8; // Alarms suppressed per port
	localparam int ST_REJ_BIT = 10; // Sticky rejected request
	localparam int ST_SDH_BIT = 11; // Copy of flavour

	// Substitute word sent downstream by a terminating port
	localparam logic [DATA_W-1:0] AIS_WORD = 16'hffff;

	// ==========================================================
	// Types
	typedef enum logic [LOOP_W-1:0] {
		LOOP_NONE = 2'h0,
		LOOP_FAC = 2'h1,
		LOOP_BAD = 2'h2,
		LOOP_TERM = 2'h3
	} plc_loop_type;

	// Gray along in service, maintenance, loop maintenance
	typedef enum logic [SVC_W-1:0] {
		SVC_IN_SERVICE = 2'h0,
		SVC_OOS_MAINT = 2'h1,
		SVC_LOOP_MAINT = 2'h3
	} plc_svc_type;

	typedef enum logic [CARD_W-1:0] {
		CARD_OTHER = 3'h0,
		CARD_TRANSPONDER = 3'h1,
		CARD_PROT_TRANSPONDER = 3'h2,
		CARD_MULTIPLEXING = 3'h3,
		CARD_PROT_MULTIPLEXING = 3'h4
	} plc_card_type;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} plc_word_type;

	typedef struct packed {
		logic maint;
		plc_loop_type loop;
	} plc_ctl_type;

	localparam plc_ctl_type CTL_RST = '{maint: 1'b0, loop: LOOP_NONE};

endpackage : plc_pkg

// file: plc_sync.sv
// Three-stage synchroniser with agreement filter for slow pins
// Assumes the pins change rarely, such as card straps
`timescale 1ns/100ps
`default_nettype none
module plc_sync
	import plc_pkg::*;
#(
	parameter int W = CARD_W
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Pin and filtered level
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level
);

	// ==========================================================
	// Stages
	logic [W-1:0] meta_reg; // First stage, read only by the second
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] level_next;

	// Level follows only when the late stages agree
	always_comb begin
		level_next = level_reg;
		if (s2_reg == s3_reg) begin
			level_next = s3_reg;
		end
	end

	// Register stages
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end else if (ce) begin
			meta_reg <= pin_in;
			s2_reg <= meta_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;

endmodule : plc_sync
`default_nettype wire

// file: plc_fifo.sv
// Small word FIFO with valid and ready on both sides
// Assumes one clock; a refused write is the writer's to hold or drop
`timescale 1ns/100ps
`default_nettype none
module plc_fifo
	import plc_pkg::*;
#(
	parameter int W = DATA_W + 1,
	parameter int DEPTH = FIFO_DEPTH_DEF
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);

	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// Storage and pointers, extra bit tells full from empty
	logic [W-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_reg;
	logic [AW:0] wr_next;
	logic [AW:0] rd_reg;
	logic [AW:0] rd_next;
	logic full;
	logic empty;

	assign empty = (wr_reg == rd_reg);
	assign full = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_reg[rd_reg[AW-1:0]];

	// Pointer advance on each handshake
	always_comb begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		if (in_valid && !full) begin
			wr_next = wr_reg + 1'b1;
		end
		if (out_ready && !empty) begin
			rd_next = rd_reg + 1'b1;
		end
	end

	// Register pointers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else if (ce) begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// Storage has no reset; empty flag hides stale words
	always_ff @(posedge clk) begin
		if (ce && in_valid && !full) begin
			mem_reg[wr_reg[AW-1:0]] <= in_data;
		end
	end

endmodule : plc_fifo
`default_nettype wire

// file: plc_top.sv
// Port loopback path control for a client and a trunk port
// Assumes line words on clk, card kind from async strap pins
// What this block does
// (RULE_01) Muxing trunk facility loop is bridged
// (RULE_02) Muxing client facility loop is terminated
// (RULE_03) Terminated loop returns only, nothing downstream
// (RULE_04) Bridged loop returns and forwards downstream
// (RULE_05) Terminated loop sends AIS downstream, bridged none
// (RULE_06) SONET loop needs maintenance; reports loop state
// (RULE_07) SDH loop needs locked maintenance; reports loop
// (RULE_08) Facility loop raises condition and alarm suppression
// (RULE_09) Client loop holds only client in loop
// (RULE_10) Trunk loop holds only trunk in loop
// (RULE_11) Facility returns outward, terminal returns inward
// (RULE_12) Client terminal turns trunk traffic back
// (RULE_13) Trunk terminal turns client traffic back
// (RULE_14) Terminal turnaround lies before line interface
// (RULE_15) Transponder terminal loops are terminated
// (RULE_16) Only transponder and muxing cards accept loops
// (RULE_17) Selector none/facility/terminal; none restores pass-through
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module plc_top
	import plc_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [REG_W-1:0] reg_rdata,
	// Card kind strap pins
	input wire logic [CARD_W-1:0] card_kind_pin,
	// Client line side
	input wire plc_word_type cl_rx,
	output logic cl_rx_ready,
	output var plc_word_type cl_tx,
	// Trunk line side
	input wire plc_word_type tr_rx,
	input wire logic tr_tx_ready,
	output var plc_word_type tr_tx,
	// Conditions, bit 0 client, bit 1 trunk
	output logic [N_PORTS-1:0] facility_loop_condition,
	output logic [N_PORTS-1:0] terminal_loop_condition,
	output logic [N_PORTS-1:0] alarms_suppressed_maint,
	// Reported service states
	output var plc_svc_type client_svc,
	output var plc_svc_type trunk_svc
);

	// ==========================================================
	// Decoding helpers

	// Loops exist only on line cards that carry clients
	function automatic logic loop_capable(input plc_card_type k);
		return (k == CARD_TRANSPONDER) || (k == CARD_PROT_TRANSPONDER) ||
			(k == CARD_MULTIPLEXING) || (k == CARD_PROT_MULTIPLEXING);
	endfunction : loop_capable

	function automatic logic is_transponder(input plc_card_type k);
		return (k == CARD_TRANSPONDER) || (k == CARD_PROT_TRANSPONDER);
	endfunction : is_transponder

	// Trunk loops bridge, client loops terminate, transponder
	// terminal loops always terminate
	function automatic logic loop_bridged(input plc_card_type k,
		input logic trunk, input plc_loop_type l);
		return trunk && !(l == LOOP_TERM && is_transponder(k)); // [RULE_01] [RULE_02] [RULE_15]
	endfunction : loop_bridged

	// Terminating port replaces the word with AIS, keeps its timing
	function automatic plc_word_type ais(input plc_word_type w);
		return '{valid: w.valid, data: AIS_WORD}; // [RULE_05]
	endfunction : ais

	function automatic logic [ADDR_W-1:0] port_ofs(input int p);
		return (p == PORT_CLIENT) ? OFS_CLIENT : OFS_TRUNK;
	endfunction : port_ofs

	function automatic logic [REG_W-1:0] ctl_word(input plc_ctl_type c);
		logic [REG_W-1:0] w;
		w = '0;
		w[CTL_MAINT_BIT] = c.maint;
		w[CTL_LOOP_LSB +: LOOP_W] = c.loop;
		return w;
	endfunction : ctl_word

	// ==========================================================
	// Card kind strap

	logic [CARD_W-1:0] card_raw; // Filtered strap level
	plc_card_type card_kind;

	plc_sync #(
		.W(CARD_W)
	) u_card_sync (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.pin_in(card_kind_pin),
		.level(card_raw)
	);

	assign card_kind = plc_card_type'(card_raw);

	// ==========================================================
	// Control registers and service states

	plc_ctl_type ctl_reg [N_PORTS]; // Admin request and loop selector
	plc_ctl_type ctl_next [N_PORTS];
	plc_svc_type svc_reg [N_PORTS]; // Reported service state
	plc_svc_type svc_next [N_PORTS];
	logic sdh_reg; // Port flavour
	logic sdh_next;
	logic rej_reg; // Sticky: a loop request was refused
	logic rej_next;

	// Register writes and loop entry gating
	always_comb begin
		plc_loop_type req;
		req = LOOP_NONE;
		sdh_next = sdh_reg;
		rej_next = rej_reg;
		// Clear goes first so a same-cycle refusal still sets
		if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_REJ_BIT]) begin
			rej_next = 1'b0;
		end
		if (reg_wr && reg_addr == OFS_CFG) begin
			sdh_next = reg_wdata[CFG_SDH_BIT];
		end
		for (int p = 0; p < N_PORTS; p++) begin
			ctl_next[p] = ctl_reg[p];
			if (reg_wr && reg_addr == port_ofs(p)) begin
				ctl_next[p].maint = reg_wdata[CTL_MAINT_BIT];
				req = plc_loop_type'(reg_wdata[CTL_LOOP_LSB +: LOOP_W]);
				if (req == LOOP_NONE) begin
					// Back to pass-through
					ctl_next[p].loop = LOOP_NONE; // [RULE_17]
				end else if (reg_wdata[CTL_MAINT_BIT] && svc_reg[p] != SVC_IN_SERVICE &&
					loop_capable(card_kind) && req != LOOP_BAD) begin
					// Port already in maintenance: loop taken
					ctl_next[p].loop = req; // [RULE_06] [RULE_07]
				end else begin
					// Refused; leaving maintenance also drops any loop
					ctl_next[p].loop = reg_wdata[CTL_MAINT_BIT] ?
						ctl_reg[p].loop : LOOP_NONE;
					rej_next = 1'b1; // [RULE_16]
				end
			end
			// A card that cannot loop never holds one
			if (!loop_capable(card_kind)) begin
				ctl_next[p].loop = LOOP_NONE; // [RULE_16]
			end
		end
	end

	// Per-port service state machine
	always_comb begin
		for (int p = 0; p < N_PORTS; p++) begin
			svc_next[p] = svc_reg[p];
			case (svc_reg[p])
				SVC_IN_SERVICE: begin
					if (ctl_next[p].maint) begin
						svc_next[p] = SVC_OOS_MAINT;
					end
				end
				SVC_OOS_MAINT: begin
					if (ctl_next[p].loop != LOOP_NONE) begin
						svc_next[p] = SVC_LOOP_MAINT; // [RULE_06] [RULE_07]
					end else if (!ctl_next[p].maint) begin
						svc_next[p] = SVC_IN_SERVICE;
					end
				end
				SVC_LOOP_MAINT: begin
					if (ctl_next[p].loop == LOOP_NONE) begin
						svc_next[p] = ctl_next[p].maint ? SVC_OOS_MAINT : SVC_IN_SERVICE; // [RULE_17]
					end
				end
				default: begin
					svc_next[p] = SVC_IN_SERVICE;
				end
			endcase
		end
	end

	// Register control state; each port moves on its own
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_reg <= '{default: CTL_RST};
			svc_reg <= '{default: SVC_IN_SERVICE};
			sdh_reg <= 1'b0;
			rej_reg <= 1'b0;
		end else if (ce) begin
			ctl_reg <= ctl_next; // [RULE_09] [RULE_10]
			svc_reg <= svc_next;
			sdh_reg <= sdh_next;
			rej_reg <= rej_next;
		end
	end

	// Conditions follow the loop selectors directly
	always_comb begin
		for (int p = 0; p < N_PORTS; p++) begin
			facility_loop_condition[p] = (ctl_reg[p].loop == LOOP_FAC); // [RULE_08]
			terminal_loop_condition[p] = (ctl_reg[p].loop == LOOP_TERM);
			alarms_suppressed_maint[p] = (ctl_reg[p].loop != LOOP_NONE); // [RULE_08]
		end
	end

	assign client_svc = svc_reg[PORT_CLIENT];
	assign trunk_svc = svc_reg[PORT_TRUNK];

	// ==========================================================
	// Register read port

	logic [REG_W-1:0] rdata_reg; // Valid only the cycle after a read
	logic [REG_W-1:0] rdata_next;

	// Read decode; unmapped offsets read zero
	always_comb begin
		rdata_next = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_CFG: begin
					rdata_next[CFG_SDH_BIT] = sdh_reg;
					rdata_next[CFG_CARD_LSB +: CARD_W] = card_raw;
				end
				OFS_CLIENT: rdata_next = ctl_word(ctl_reg[PORT_CLIENT]);
				OFS_TRUNK: rdata_next = ctl_word(ctl_reg[PORT_TRUNK]);
				OFS_STATUS: begin
					rdata_next[ST_SVC_LSB +: SVC_W] = svc_reg[PORT_CLIENT];
					rdata_next[ST_SVC_LSB + SVC_W +: SVC_W] = svc_reg[PORT_TRUNK];
					rdata_next[ST_FAC_LSB +: N_PORTS] = facility_loop_condition;
					rdata_next[ST_TERM_LSB +: N_PORTS] = terminal_loop_condition;
					rdata_next[ST_SUPP_LSB +: N_PORTS] = alarms_suppressed_maint;
					rdata_next[ST_REJ_BIT] = rej_reg;
					rdata_next[ST_SDH_BIT] = sdh_reg;
				end
				default: rdata_next = '0;
			endcase
		end
	end

	// Register read data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= '0;
		end else if (ce) begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ==========================================================
	// Data path

	plc_loop_type lc; // Client selector
	plc_loop_type lt; // Trunk selector
	logic cb; // Client loop bridges
	logic tb; // Trunk loop bridges
	plc_word_type fifo_in; // Toward trunk line interface
	plc_word_type cl_tx_reg; // Toward client line interface
	plc_word_type cl_tx_next;
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data; // Word data only; valid comes from the buffer

	assign lc = ctl_reg[PORT_CLIENT].loop;
	assign lt = ctl_reg[PORT_TRUNK].loop;
	assign cb = loop_bridged(card_kind, 1'b0, lc);
	assign tb = loop_bridged(card_kind, 1'b1, lt);

	// Source of the client transmit word; client loop has priority
	always_comb begin
		if (lc == LOOP_FAC) begin
			cl_tx_next = cl_rx; // [RULE_11]
		end else if (lc == LOOP_TERM) begin
			cl_tx_next = cb ? tr_rx : ais(tr_rx); // [RULE_03] [RULE_05] [RULE_15]
		end else if (lt == LOOP_TERM) begin
			cl_tx_next = cl_rx; // [RULE_13]
		end else if (lt == LOOP_FAC) begin
			cl_tx_next = tb ? tr_rx : ais(tr_rx); // [RULE_01] [RULE_04]
		end else begin
			cl_tx_next = tr_rx;
		end
	end

	// Source of the trunk transmit word; trunk loop has priority.
	// Client terminal turnaround sits ahead of the buffer and line
	// interface, so turned trunk words pass through both.
	always_comb begin
		if (lt == LOOP_FAC) begin
			fifo_in = tr_rx; // [RULE_01] [RULE_11]
		end else if (lt == LOOP_TERM) begin
			fifo_in = tb ? cl_rx : ais(cl_rx); // [RULE_05] [RULE_15]
		end else if (lc == LOOP_TERM) begin
			fifo_in = tr_rx; // [RULE_12] [RULE_14]
		end else if (lc == LOOP_FAC) begin
			fifo_in = cb ? cl_rx : ais(cl_rx); // [RULE_02] [RULE_03]
		end else begin
			fifo_in = cl_rx;
		end
	end

	// Client transmit register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cl_tx_reg <= '0;
		end else if (ce) begin
			cl_tx_reg <= cl_tx_next;
		end
	end

	assign cl_tx = cl_tx_reg;

	// Trunk buffer; trunk receive has no ready, so a looped word
	// meeting a full buffer is lost
	plc_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_trunk_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.in_valid(fifo_in.valid),
		.in_data(fifo_in.data),
		.in_ready(cl_rx_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(tr_tx_ready)
	);

	assign tr_tx = '{valid: fifo_out_valid, data: fifo_out_data};

	// ==========================================================
	// Checks

	default clocking cb_clk @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence client_wr_s(plc_loop_type l);
		ce && reg_wr && reg_addr == OFS_CLIENT &&
			reg_wdata[CTL_LOOP_LSB +: LOOP_W] == l;
	endsequence

	sequence trunk_clear_s;
		ce && reg_wr && reg_addr == OFS_TRUNK &&
			reg_wdata[CTL_LOOP_LSB +: LOOP_W] == LOOP_NONE;
	endsequence

	trunk_fac_bridge_a: assert property ( // [RULE_01] [RULE_04]
		(ce && lt == LOOP_FAC && lc == LOOP_NONE && tr_rx.valid)
			|-> (fifo_in == tr_rx) ##1 (cl_tx == $past(tr_rx)))
		else $error("trunk facility loop not bridged");

	client_fac_term_a: assert property ( // [RULE_02] [RULE_03]
		(ce && lc == LOOP_FAC && lt == LOOP_NONE && cl_rx.valid)
			|-> (fifo_in.data == AIS_WORD) ##1 (cl_tx == $past(cl_rx)))
		else $error("client facility loop not terminated");

	term_ais_a: assert property ( // [RULE_05]
		(ce && lc == LOOP_TERM && tr_rx.valid)
			|=> (cl_tx.valid && cl_tx.data == AIS_WORD))
		else $error("no AIS below terminated loop");

	loop_gate_a: assert property ( // [RULE_06] [RULE_07]
		(client_wr_s(LOOP_FAC) ##0 (svc_reg[PORT_CLIENT] == SVC_IN_SERVICE))
			|=> (lc == LOOP_NONE && rej_reg))
		else $error("loop taken outside maintenance");

	loop_state_a: assert property ( // [RULE_06] [RULE_07]
		(lc != LOOP_NONE) |-> (client_svc == SVC_LOOP_MAINT))
		else $error("looped port not in loop state");

	fac_cond_a: assert property ( // [RULE_08]
		$rose(facility_loop_condition[PORT_TRUNK])
			|-> (alarms_suppressed_maint[PORT_TRUNK] && trunk_svc == SVC_LOOP_MAINT))
		else $error("facility loop without condition");

	other_port_a: assert property ( // [RULE_09] [RULE_10]
		(lc != LOOP_NONE && lt == LOOP_NONE) |-> (trunk_svc != SVC_LOOP_MAINT))
		else $error("unlooped port held in loop state");

	term_client_a: assert property ( // [RULE_12] [RULE_14]
		(ce && lc == LOOP_TERM && lt == LOOP_NONE && tr_rx.valid) |-> (fifo_in == tr_rx))
		else $error("client terminal loop not turned");

	term_trunk_a: assert property ( // [RULE_11] [RULE_13]
		(ce && lt == LOOP_TERM && lc == LOOP_NONE && cl_rx.valid)
			|=> (cl_tx == $past(cl_rx)))
		else $error("trunk terminal loop not turned");

	xpdr_term_a: assert property ( // [RULE_15]
		(ce && is_transponder(card_kind) && lt == LOOP_TERM && lc == LOOP_NONE && cl_rx.valid)
			|-> (fifo_in.data == AIS_WORD))
		else $error("transponder terminal loop bridged");

	card_reject_a: assert property ( // [RULE_16]
		(ce && !loop_capable(card_kind)) |=> (lc == LOOP_NONE && lt == LOOP_NONE))
		else $error("loop held on incapable card");

	loop_clear_a: assert property ( // [RULE_17]
		trunk_clear_s |=> (lt == LOOP_NONE && !facility_loop_condition[PORT_TRUNK] &&
			!terminal_loop_condition[PORT_TRUNK]))
		else $error("loop not cleared");

endmodule : plc_top
`default_nettype wire

// file: plc_span_model.sv
// Span side model: test set taking words off the trunk transmit side
// Assumes the bench sets the pace; taken words are queued for checking
`timescale 1ns/100ps
`default_nettype none
module plc_span_model
	import plc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pace: 0 prompt, 1 slow, 2 stalled
	input wire logic [1:0] pace,
	// Trunk transmit side
	input wire plc_word_type tr_tx,
	output logic tr_tx_ready
);
	// ==========================================================
	// Taken words, oldest first
	logic [DATA_W-1:0] got[$];

	// Ready changes just after an edge; a word is taken when both are high
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tr_tx_ready <= 1'b0;
		end else begin
			if (tr_tx.valid && tr_tx_ready) begin
				got.push_back(tr_tx.data);
			end
			// Slow pace stalls about three cycles in four
			tr_tx_ready <= (pace == 2'h0) || (pace == 2'h1 && $urandom_range(3) == 0);
		end
	end
endmodule : plc_span_model
`default_nettype wire

// file: plc_top_test.sv
// Self-checking bench for the port loopback block
// Assumes the span model paces the trunk transmit side
`timescale 1ns/100ps
`default_nettype none
module plc_top_test
	import plc_pkg::*;
;
	// ==========================================================
	// Stimulus and observed signals
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [REG_W-1:0] reg_wdata = 16'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ce = 1'b1;
	logic [REG_W-1:0] reg_rdata;
	logic [CARD_W-1:0] card = 3'h0;
	plc_word_type cl_rx = '0;
	plc_word_type tr_rx = '0;
	plc_word_type cl_tx;
	plc_word_type tr_tx;
	logic cl_rx_ready;
	logic tr_tx_ready;
	logic [1:0] pace = 2'h0;
	logic [N_PORTS-1:0] fac;
	logic [N_PORTS-1:0] term;
	logic [N_PORTS-1:0] supp;
	plc_svc_type csvc;
	plc_svc_type tsvc;
	int fail_count = 0;
	int n_tests = 0;

	always #10 clk = ~clk;

	plc_top plc_top_i (.clk(clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.card_kind_pin(card), .cl_rx(cl_rx), .cl_rx_ready(cl_rx_ready), .cl_tx(cl_tx),
		.tr_rx(tr_rx), .tr_tx_ready(tr_tx_ready), .tr_tx(tr_tx),
		.facility_loop_condition(fac), .terminal_loop_condition(term),
		.alarms_suppressed_maint(supp), .client_svc(csvc), .trunk_svc(tsvc));
	plc_span_model plc_span_model_i (.clk(clk), .arst_n(arst_n), .pace(pace),
		.tr_tx(tr_tx), .tr_tx_ready(tr_tx_ready));

	// ==========================================================
	// Checking and closing
	task automatic chk(input string what, input logic [REG_W:0] seen, input logic [REG_W:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic conclude();
		if (fail_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	// ==========================================================
	// Register port cycles, one strobe cycle each
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// ==========================================================
	// Expectations
	function automatic plc_word_type word(input logic v);
		return '{valid: v, data: DATA_W'($urandom)};
	endfunction : word

	function automatic plc_word_type ais(input plc_word_type w);
		return '{valid: w.valid, data: AIS_WORD};
	endfunction : ais

	// Client and trunk transmit words with one port looped
	function automatic void paths(input logic [CARD_W-1:0] cd, input int p, input plc_loop_type l,
		input plc_word_type c, input plc_word_type t, output plc_word_type ec,
		output plc_word_type et);
		ec = t;
		et = c;
		if (l == LOOP_FAC && p == PORT_CLIENT) begin
			ec = c;
			et = ais(c);
		end else if (l == LOOP_FAC) begin
			et = t;
		end else if (l == LOOP_TERM && p == PORT_CLIENT) begin
			ec = ais(t);
			et = t;
		end else if (l == LOOP_TERM) begin
			ec = c;
			et = (cd == CARD_TRANSPONDER || cd == CARD_PROT_TRANSPONDER) ? ais(c) : c;
		end
	endfunction : paths

	// Status word with one port looped, the other in service
	function automatic logic [REG_W-1:0] status(input int p, input plc_loop_type l, input logic sdh);
		logic [REG_W-1:0] s;
		s = 16'h0;
		s[ST_SDH_BIT] = sdh;
		if (l != LOOP_NONE) begin
			s[ST_SVC_LSB + 2 * p +: 2] = SVC_LOOP_MAINT;
			s[ST_SUPP_LSB + p] = 1'b1;
			s[(l == LOOP_FAC ? ST_FAC_LSB : ST_TERM_LSB) + p] = 1'b1;
		end
		return s;
	endfunction : status

	// One word each way, checked on both transmit sides
	task automatic traffic(input logic [CARD_W-1:0] cd, input int p, input plc_loop_type l);
		plc_word_type c;
		plc_word_type t;
		plc_word_type ec;
		plc_word_type et;
		c = word(1'b1);
		t = word(1'b1);
		paths(cd, p, l, c, t, ec, et);
		@(posedge clk);
		cl_rx <= c;
		tr_rx <= t;
		@(posedge clk);
		cl_rx <= word(1'b0);
		tr_rx <= word(1'b0);
		#1;
		chk("client tx", cl_tx, ec);
		chk("trunk tx", tr_tx, et);
	endtask : traffic

	// ==========================================================
	// Main sequence
	initial begin
		logic [REG_W-1:0] r;
		logic [REG_W-1:0] e;
		logic [CARD_W-1:0] cd;
		logic [ADDR_W-1:0] ofs;
		logic sdh;
		plc_loop_type l;
		plc_word_type sent[5];
		int p;
		void'($urandom(32'hc14e));
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		rd(OFS_STATUS, r);
		chk("reset status", r, 16'h0);
		wr(4'h2, 16'hffff);
		rd(4'h2, r);
		chk("unmapped", r, 16'h0);
		// Every capable card, both ports, both loop kinds
		for (int i = 0; i < 16; i++) begin
			cd = 3'(i / 4 + 1);
			p = i % 2;
			l = i[1] ? LOOP_TERM : LOOP_FAC;
			sdh = i[0] ^ i[3];
			ofs = p ? OFS_TRUNK : OFS_CLIENT;
			@(posedge clk);
			card <= cd;
			repeat (8) @(posedge clk);
			wr(OFS_CFG, {15'h0038, sdh});
			rd(OFS_CFG, r);
			chk("config", r, {9'h0, cd, 3'h0, sdh});
			wr(ofs, 16'h0001);
			chk("maint state", p ? tsvc : csvc, SVC_OOS_MAINT);
			wr(ofs, {13'h0, l, 1'b1});
			rd(OFS_STATUS, r);
			e = status(p, l, sdh);
			chk("status", r, e);
			chk("outputs", {supp, term, fac, tsvc, csvc}, e[9:0]);
			traffic(cd, p, l);
			wr(ofs, 16'h0000);
			rd(OFS_STATUS, r);
			chk("cleared", r, status(p, LOOP_NONE, sdh));
			traffic(cd, p, LOOP_NONE);
		end
		// Refused requests: card, port, first and second control word
		foreach (sent[i]) begin
			if (i < 4) begin
				e = (i == 0) ? 16'h0013 : (i == 1) ? 16'h3002 : (i == 2) ? 16'h3015 : 16'h6117;
				ofs = e[8] ? OFS_TRUNK : OFS_CLIENT;
				@(posedge clk);
				card <= e[14:12];
				repeat (8) @(posedge clk);
				wr(ofs, {12'h0, e[7:4]});
				wr(ofs, {12'h0, e[3:0]});
				rd(OFS_STATUS, r);
				chk("refused", r & 16'h07f0, 16'h0400);
				wr(OFS_STATUS, 16'h0400);
				wr(ofs, 16'h0000);
				rd(OFS_STATUS, r);
				chk("reject clear", r[ST_REJ_BIT], 1'b0);
			end
		end
		// Clock enable low: a write must not land
		@(posedge clk);
		ce <= 1'b0;
		wr(OFS_CFG, 16'h0001);
		@(posedge clk);
		ce <= 1'b1;
		rd(OFS_CFG, r);
		chk("frozen", r, 16'h0060);
		// Fill the trunk buffer against a stalled span, then drain slowly
		plc_span_model_i.got.delete();
		@(posedge clk);
		pace <= 2'h2;
		foreach (sent[i]) begin
			@(posedge clk);
			sent[i] = word(1'b1);
			cl_rx <= sent[i];
		end
		@(posedge clk);
		cl_rx <= word(1'b0);
		pace <= 2'h1;
		#1;
		chk("buffer full", cl_rx_ready, 1'b0);
		for (int k = 0; k < 200 && plc_span_model_i.got.size() < 4; k++) begin
			@(posedge clk);
		end
		#1;
		if (plc_span_model_i.got.size() != 4) begin
			// Span never took the whole buffer: counts as a mismatch
			fail_count++;
		end else begin
			for (int i = 0; i < 4; i++) begin
				chk("drain", plc_span_model_i.got[i], sent[i].data);
			end
		end
		chk("drained", tr_tx.valid, 1'b0);
		chk("ready again", cl_rx_ready, 1'b1);
		conclude();
	end
endmodule : plc_top_test
`default_nettype wire
